// [ppr_pkg.sv]
package ppr_pkg;

   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int CLK_FREQ_HZ     = 10_000_000;
   localparam int SAMPLE_TIME_US  = 1000;
   localparam int SAMPLE_CYCLES   = SAMPLE_TIME_US * (CLK_FREQ_HZ / 1_000_000);
   localparam int FRAC            = 10;       // fraction bits of filter and ramp states
   localparam int FULL_SCALE      = 10000;    // 100.00 percent in 0.01 percent steps
   localparam int WEIGHT_ONE      = 256;      // gain interpolation weight for set two

   // ---------------------------------------------------------------
   // register offsets (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL    = 8'h00;
   localparam logic [7:0] OFS_DIG_SP  = 8'h04;
   localparam logic [7:0] OFS_RANGE   = 8'h08;
   localparam logic [7:0] OFS_KP1     = 8'h0C;
   localparam logic [7:0] OFS_TI1     = 8'h10;
   localparam logic [7:0] OFS_TD1     = 8'h14;
   localparam logic [7:0] OFS_KP2     = 8'h18;
   localparam logic [7:0] OFS_TI2     = 8'h1C;
   localparam logic [7:0] OFS_TD2     = 8'h20;
   localparam logic [7:0] OFS_REV_CUT = 8'h24;
   localparam logic [7:0] OFS_DEAD    = 8'h28;
   localparam logic [7:0] OFS_DCLIP   = 8'h2C;
   localparam logic [7:0] OFS_RAMP    = 8'h30;
   localparam logic [7:0] OFS_FBF     = 8'h34;
   localparam logic [7:0] OFS_OUTF    = 8'h38;
   localparam logic [7:0] OFS_SW_LO   = 8'h3C;
   localparam logic [7:0] OFS_SW_HI   = 8'h40;
   localparam logic [7:0] OFS_FMAX    = 8'h44;
   localparam logic [7:0] OFS_DISPLAY = 8'h48;
   localparam logic [7:0] OFS_FREQ    = 8'h4C;

   // ---------------------------------------------------------------
   // reset values
   // ---------------------------------------------------------------
   localparam logic [15:0] RST_DIG_SP = 16'h1388;  // 50.00 percent
   localparam logic [15:0] RST_RANGE  = 16'h03E8;  // 1000
   localparam logic [15:0] RST_KP     = 16'h00C8;  // 20.0
   localparam logic [15:0] RST_TI     = 16'h00C8;  // 2.00 s
   localparam logic [15:0] RST_DCLIP  = 16'h000A;  // 0.10 percent
   localparam logic [15:0] RST_SW_LO  = 16'h07D0;  // 20.00 percent
   localparam logic [15:0] RST_SW_HI  = 16'h1F40;  // 80.00 percent
   localparam logic [15:0] RST_FMAX   = 16'h1388;  // 50.00 Hz, plain default

   // ---------------------------------------------------------------
   // carriers
   // ---------------------------------------------------------------
   typedef struct packed {
      logic signed [15:0] ai_one;
      logic signed [15:0] ai_two;
      logic signed [15:0] ai_three;
      logic signed [15:0] pulse;
      logic signed [15:0] comm_sp;
      logic signed [15:0] comm_fb;
      logic signed [15:0] multistep;
   } ppr_src_type;

   typedef struct packed {
      logic [2:0]  sp_src;
      logic [3:0]  fb_src;
      logic        dir;
      logic [1:0]  sw_mode;
      logic [15:0] dig_sp;
      logic [15:0] range;
      logic [15:0] kp1;
      logic [15:0] ti1;
      logic [15:0] td1;
      logic [15:0] kp2;
      logic [15:0] ti2;
      logic [15:0] td2;
      logic [15:0] rev_cut;
      logic [15:0] dead;
      logic [15:0] dclip;
      logic [15:0] ramp_t;
      logic [15:0] fbf_t;
      logic [15:0] outf_t;
      logic [15:0] sw_lo;
      logic [15:0] sw_hi;
      logic [15:0] fmax;
   } ppr_cfg_type;

   localparam ppr_cfg_type CFG_RST = '{
      sp_src: 3'h0, fb_src: 4'h0, dir: 1'b0, sw_mode: 2'h0,
      dig_sp: RST_DIG_SP, range: RST_RANGE,
      kp1: RST_KP, ti1: RST_TI, td1: 16'h0000,
      kp2: RST_KP, ti2: RST_TI, td2: 16'h0000,
      rev_cut: 16'h0000, dead: 16'h0000, dclip: RST_DCLIP,
      ramp_t: 16'h0000, fbf_t: 16'h0000, outf_t: 16'h0000,
      sw_lo: RST_SW_LO, sw_hi: RST_SW_HI, fmax: RST_FMAX};

   typedef struct packed {
      ppr_cfg_type        cfg;
      logic [1:0]         rev_sync;
      logic [1:0]         gsw_sync;
      logic [15:0]        tick_cnt;
      logic               tick;
      logic signed [31:0] sp_ramp;
      logic signed [31:0] fb_filt;
      logic signed [15:0] fb_prev;
      logic signed [31:0] integ;
      logic signed [31:0] out_filt;
      logic signed [15:0] freq;
      logic signed [31:0] sp_disp;
      logic signed [31:0] fb_disp;
      logic [31:0]        prdata;
   } ppr_state_type;

endpackage : ppr_pkg

// [ppr_regulator.sv]
// Implementation choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ns
module ppr_regulator #(
   parameter int SAMPLE_CYCLES = ppr_pkg::SAMPLE_CYCLES
) (
   input  wire logic               pclk,
   input  wire logic               presetn,
   input  wire logic [7:0]         paddr,
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [31:0]        pwdata,
   output logic [31:0]             prdata,
   output logic                    pready,
   output logic                    pslverr,
   input  wire ppr_pkg::ppr_src_type sources,
   input  wire logic               reverse_terminal,
   input  wire logic               gain_switch_terminal,
   output logic signed [15:0]      output_frequency,
   output logic signed [31:0]      setpoint_display,
   output logic signed [31:0]      feedback_display
);

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------

   // clamp a signed value into [lo, hi]
   // 48 bits leave headroom for gain products
   function automatic logic signed [47:0] sat(input logic signed [47:0] v,
                                              input logic signed [47:0] lo,
                                              input logic signed [47:0] hi);
      if (v < lo) begin
         return lo;
      end else if (v > hi) begin
         return hi;
      end
      return v;
   endfunction : sat

   // clamp a written field into its settable range
   // unsigned compare; both bounds inclusive
   function automatic logic [15:0] lim(input logic [15:0] v, input logic [15:0] lo,
                                       input logic [15:0] hi);
      if (v < lo) begin
         return lo;
      end else if (v > hi) begin
         return hi;
      end
      return v;
   endfunction : lim

   // register decode shared by write enable and error answer
   // only aligned words up to the last register answer
   function automatic logic mapped(input logic [7:0] a);
      return (a[1:0] == 2'h0) && (a <= ppr_pkg::OFS_FREQ);
   endfunction : mapped

   // first-order low-pass; time in 0.01 s, state scaled by 2^FRAC
   // zero time skips the divide and passes the input on
   // truncating divide: long times settle a count short
   function automatic logic signed [31:0] lpf(input logic signed [31:0] prev,
                                              input logic signed [47:0] x,
                                              input logic [15:0] t);
      logic signed [47:0] xs;
      logic signed [47:0] den;
      xs  = x <<< ppr_pkg::FRAC;
      den = 48'(t) * 48'sd10000 + 48'(ppr_pkg::SAMPLE_TIME_US);
      if (t == 16'h0000) begin
         return 32'(xs);
      end
      return 32'(48'(prev) + (xs - 48'(prev)) * 48'(ppr_pkg::SAMPLE_TIME_US) / den);
   endfunction : lpf

   // interpolate one gain between set one and set two
   // weight 0 is set one, WEIGHT_ONE is set two
   function automatic logic [15:0] lerp(input logic [15:0] a, input logic [15:0] b,
                                        input logic [8:0] w);
      logic signed [31:0] diff;
      diff = 32'($signed({1'b0, b})) - 32'($signed({1'b0, a}));
      return 16'(32'($signed({1'b0, a})) + diff * 32'($signed({1'b0, w})) /
                 32'(ppr_pkg::WEIGHT_ONE));
   endfunction : lerp

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   ppr_pkg::ppr_state_type q;
   ppr_pkg::ppr_state_type d;
   // one comb copy of the state, one register

   // bus decode
   logic                   wr_en;
   logic                   rd_setup;

   // selected inputs and ramped setpoint
   logic signed [47:0]     target;
   logic signed [47:0]     fb_raw;
   logic signed [47:0]     a1;
   logic signed [47:0]     a2;
   logic signed [47:0]     step;
   logic signed [47:0]     sp;
   logic signed [47:0]     fb;

   // deviation and regulator terms
   logic signed [47:0]     dev;
   logic signed [47:0]     absdev;
   logic signed [47:0]     err;
   logic signed [47:0]     p_term;
   logic signed [47:0]     i_inc;
   logic signed [47:0]     d_term;
   logic signed [47:0]     u;
   logic signed [47:0]     f_raw;
   logic signed [47:0]     absf;

   // gain blend
   logic signed [47:0]     lo;
   logic signed [47:0]     hi;
   logic                   dir;
   logic [8:0]             w;
   logic [15:0]            kp;
   logic [15:0]            ti;
   logic [15:0]            td;

   // apb answers at once: zero wait states
   // every register is one flop deep, nothing stalls
   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~mapped(paddr);
   assign prdata  = q.prdata;

   // outputs come straight from flops
   assign output_frequency = q.freq;
   assign setpoint_display = q.sp_disp;
   assign feedback_display = q.fb_disp;

   assign wr_en    = psel & penable & pwrite & mapped(paddr);
   assign rd_setup = psel & ~penable & ~pwrite;

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      // every field holds unless a branch sets it
      d = q;
      a1 = 48'(sources.ai_one);
      a2 = 48'(sources.ai_two);
      lo = 48'($signed({1'b0, q.cfg.sw_lo}));
      hi = 48'($signed({1'b0, q.cfg.sw_hi}));

      // terminal synchronisers; only stage two feeds logic
      // level inputs: a pulse shorter than a clock may be lost
      d.rev_sync = {q.rev_sync[0], reverse_terminal};
      d.gsw_sync = {q.gsw_sync[0], gain_switch_terminal};

      // sample tick
      // free-running; first tick SAMPLE_CYCLES after reset
      d.tick     = (q.tick_cnt == 16'(SAMPLE_CYCLES - 1));
      d.tick_cnt = d.tick ? 16'h0000 : q.tick_cnt + 16'h0001;

      // setpoint source
      // code 0 and any unknown code pick the stored value
      unique case (q.cfg.sp_src)
         3'h1:    target = a1;
         3'h2:    target = a2;
         3'h3:    target = 48'(sources.ai_three);
         3'h4:    target = 48'(sources.pulse);
         3'h5:    target = 48'(sources.comm_sp);
         3'h6:    target = 48'(sources.multistep);
         default: target = 48'($signed({1'b0, q.cfg.dig_sp}));
      endcase
      target = sat(target, 48'sd0, 48'(ppr_pkg::FULL_SCALE));

      // feedback source
      // magnitude codes fold negative inputs first
      unique case (q.cfg.fb_src)
         4'h1:    fb_raw = a2;
         4'h2:    fb_raw = 48'(sources.ai_three);
         4'h3:    fb_raw = a1 - a2;
         4'h4:    fb_raw = 48'(sources.pulse);
         4'h5:    fb_raw = 48'(sources.comm_fb);
         4'h6:    fb_raw = a1 + a2;
         4'h7:    fb_raw = ((a1 < 0 ? -a1 : a1) > (a2 < 0 ? -a2 : a2)) ?
                           (a1 < 0 ? -a1 : a1) : (a2 < 0 ? -a2 : a2);
         4'h8:    fb_raw = ((a1 < 0 ? -a1 : a1) < (a2 < 0 ? -a2 : a2)) ?
                           (a1 < 0 ? -a1 : a1) : (a2 < 0 ? -a2 : a2);
         default: fb_raw = a1;
      endcase
      fb_raw = sat(fb_raw, 48'sd0, 48'(ppr_pkg::FULL_SCALE));

      // setpoint ramp, zero time jumps straight to target
      // step is the full-scale slope per tick; no overshoot
      step = 48'(1 << ppr_pkg::FRAC) * 48'(ppr_pkg::SAMPLE_TIME_US) /
             48'($signed({1'b0, (q.cfg.ramp_t == 16'h0000) ? 16'h0001 : q.cfg.ramp_t}));
      if (q.cfg.ramp_t == 16'h0000) begin
         sp = target <<< ppr_pkg::FRAC;
      end else if (48'(q.sp_ramp) < (target <<< ppr_pkg::FRAC)) begin
         sp = sat(48'(q.sp_ramp) + step, 48'(q.sp_ramp), target <<< ppr_pkg::FRAC);
      end else begin
         sp = sat(48'(q.sp_ramp) - step, target <<< ppr_pkg::FRAC, 48'(q.sp_ramp));
      end

      // feedback filter
      // filtering adds loop lag; zero disables it
      fb = 48'(lpf(q.fb_filt, fb_raw, q.cfg.fbf_t));

      // deviation in 0.01 percent, fraction dropped
      dev    = (sp - fb) >>> ppr_pkg::FRAC;
      absdev = dev < 0 ? -dev : dev;
      absf   = q.freq < 0 ? -48'(q.freq) : 48'(q.freq);

      // terminal inverts direction
      // flips whichever direction is configured
      dir = q.cfg.dir ^ q.rev_sync[1];
      err = dir ? -dev : dev;

      unique case (q.cfg.sw_mode)
         2'h0: w = 9'h000;
         2'h1: w = q.gsw_sync[1] ? 9'(ppr_pkg::WEIGHT_ONE) : 9'h000;
         // thresholds stay ordered on write, so hi - lo > 0 here
         2'h2: begin
            if (absdev <= lo) begin
               w = 9'h000;
            end else if (absdev >= hi) begin
               w = 9'(ppr_pkg::WEIGHT_ONE);
            end else begin
               w = 9'((absdev - lo) * 48'(ppr_pkg::WEIGHT_ONE) / (hi - lo));
            end
         end
         // blends from the last output, so it lags one tick
         2'h3: w = 9'(sat(absf * 48'(ppr_pkg::WEIGHT_ONE) /
                          48'($signed({1'b0, q.cfg.fmax})),
                          48'sd0, 48'(ppr_pkg::WEIGHT_ONE)));
      endcase

      // second set blended in
      // a zero blended ti would divide by zero: floor it
      kp = lerp(q.cfg.kp1, q.cfg.kp2, w);
      ti = lerp(q.cfg.ti1, q.cfg.ti2, w);
      td = lerp(q.cfg.td1, q.cfg.td2, w);
      if (ti == 16'h0000) begin
         ti = 16'h0001;
      end

      // gain 1000 (100.0) times full deviation gives full scale
      // gains in tenths, so the divide is by a constant
      p_term = err * 48'($signed({1'b0, kp})) / 48'sd1000;
      // full deviation integrates to full scale in one ti
      // fraction bits kept so a slow ti still moves it
      i_inc  = (err <<< ppr_pkg::FRAC) * 48'(ppr_pkg::SAMPLE_TIME_US) /
               (48'($signed({1'b0, ti})) * 48'sd10000);
      // rate of feedback times derivative time, in ms
      // feedback only: a setpoint step gives no kick
      d_term = (48'(q.fb_prev) - (fb >>> ppr_pkg::FRAC)) *
               48'($signed({1'b0, td})) * 48'sd1000 / 48'(ppr_pkg::SAMPLE_TIME_US);
      d_term = dir ? -d_term : d_term;
      d_term = sat(d_term, -48'($signed({1'b0, q.cfg.dclip})),
                   48'($signed({1'b0, q.cfg.dclip})));

      // total correction saturates at full scale
      u = sat(p_term + (48'(q.integ) >>> ppr_pkg::FRAC) + d_term,
              -48'(ppr_pkg::FULL_SCALE), 48'(ppr_pkg::FULL_SCALE));
      f_raw = u * 48'($signed({1'b0, q.cfg.fmax})) / 48'(ppr_pkg::FULL_SCALE);
      // reverse cutoff
      // a zero cutoff forbids reverse rotation
      if (f_raw < -48'($signed({1'b0, q.cfg.rev_cut}))) begin
         f_raw = -48'($signed({1'b0, q.cfg.rev_cut}));
      end

      // sampled update of every dynamic state
      if (q.tick) begin
         d.sp_ramp = 32'(sp);
         d.fb_filt = 32'(fb);
         d.fb_prev = 16'(fb >>> ppr_pkg::FRAC);
         d.sp_disp = 32'((sp >>> ppr_pkg::FRAC) * 48'($signed({1'b0, q.cfg.range})) /
                         48'(ppr_pkg::FULL_SCALE));
         d.fb_disp = 32'((fb >>> ppr_pkg::FRAC) * 48'($signed({1'b0, q.cfg.range})) /
                         48'(ppr_pkg::FULL_SCALE));
         // dead band holds integral and output
         // equality with the band still adjusts
         if (absdev >= 48'($signed({1'b0, q.cfg.dead}))) begin
            d.integ    = 32'(sat(48'(q.integ) + i_inc,
                                 -(48'(ppr_pkg::FULL_SCALE) <<< ppr_pkg::FRAC),
                                 48'(ppr_pkg::FULL_SCALE) <<< ppr_pkg::FRAC));
            // output filter
            // filter state frozen too inside the band
            d.out_filt = lpf(q.out_filt, f_raw, q.cfg.outf_t);
            d.freq     = 16'(48'(d.out_filt) >>> ppr_pkg::FRAC);
         end
      end

      // read data captured in setup, shown in access phase
      // so prdata stands through the whole access phase
      if (rd_setup) begin
         unique case (paddr)
            ppr_pkg::OFS_CTRL:    d.prdata = {21'h0, q.cfg.sw_mode, q.cfg.dir,
                                              q.cfg.fb_src, 1'b0, q.cfg.sp_src};
            ppr_pkg::OFS_DIG_SP:  d.prdata = {16'h0, q.cfg.dig_sp};
            ppr_pkg::OFS_RANGE:   d.prdata = {16'h0, q.cfg.range};
            ppr_pkg::OFS_KP1:     d.prdata = {16'h0, q.cfg.kp1};
            ppr_pkg::OFS_TI1:     d.prdata = {16'h0, q.cfg.ti1};
            ppr_pkg::OFS_TD1:     d.prdata = {16'h0, q.cfg.td1};
            ppr_pkg::OFS_KP2:     d.prdata = {16'h0, q.cfg.kp2};
            ppr_pkg::OFS_TI2:     d.prdata = {16'h0, q.cfg.ti2};
            ppr_pkg::OFS_TD2:     d.prdata = {16'h0, q.cfg.td2};
            ppr_pkg::OFS_REV_CUT: d.prdata = {16'h0, q.cfg.rev_cut};
            ppr_pkg::OFS_DEAD:    d.prdata = {16'h0, q.cfg.dead};
            ppr_pkg::OFS_DCLIP:   d.prdata = {16'h0, q.cfg.dclip};
            ppr_pkg::OFS_RAMP:    d.prdata = {16'h0, q.cfg.ramp_t};
            ppr_pkg::OFS_FBF:     d.prdata = {16'h0, q.cfg.fbf_t};
            ppr_pkg::OFS_OUTF:    d.prdata = {16'h0, q.cfg.outf_t};
            ppr_pkg::OFS_SW_LO:   d.prdata = {16'h0, q.cfg.sw_lo};
            ppr_pkg::OFS_SW_HI:   d.prdata = {16'h0, q.cfg.sw_hi};
            ppr_pkg::OFS_FMAX:    d.prdata = {16'h0, q.cfg.fmax};
            ppr_pkg::OFS_DISPLAY: d.prdata = {q.fb_disp[15:0], q.sp_disp[15:0]};
            ppr_pkg::OFS_FREQ:    d.prdata = {{16{q.freq[15]}}, q.freq};
            default:              d.prdata = 32'h0000_0000;
         endcase
      end

      // writes land at the access edge; values clamped to settable range
      // no illegal value is stored, but a lowered fmax can leave rev_cut above it
      if (wr_en) begin
         unique case (paddr)
            ppr_pkg::OFS_CTRL: begin
               d.cfg.sp_src  = (pwdata[2:0] > 3'h6) ? 3'h6 : pwdata[2:0];
               d.cfg.fb_src  = (pwdata[7:4] > 4'h8) ? 4'h8 : pwdata[7:4];
               d.cfg.dir     = pwdata[8];
               d.cfg.sw_mode = pwdata[10:9];
            end
            ppr_pkg::OFS_DIG_SP:  d.cfg.dig_sp  = lim(pwdata[15:0], 16'h0000, 16'h2710);
            ppr_pkg::OFS_RANGE:   d.cfg.range   = lim(pwdata[15:0], 16'h000A, 16'hFFFF);
            ppr_pkg::OFS_KP1:     d.cfg.kp1     = lim(pwdata[15:0], 16'h0000, 16'h03E8);
            ppr_pkg::OFS_TI1:     d.cfg.ti1     = lim(pwdata[15:0], 16'h0001, 16'h03E8);
            ppr_pkg::OFS_TD1:     d.cfg.td1     = lim(pwdata[15:0], 16'h0000, 16'h2710);
            ppr_pkg::OFS_KP2:     d.cfg.kp2     = lim(pwdata[15:0], 16'h0000, 16'h03E8);
            ppr_pkg::OFS_TI2:     d.cfg.ti2     = lim(pwdata[15:0], 16'h0001, 16'h03E8);
            ppr_pkg::OFS_TD2:     d.cfg.td2     = lim(pwdata[15:0], 16'h0000, 16'h2710);
            ppr_pkg::OFS_REV_CUT: d.cfg.rev_cut = lim(pwdata[15:0], 16'h0000, q.cfg.fmax);
            ppr_pkg::OFS_DEAD:    d.cfg.dead    = lim(pwdata[15:0], 16'h0000, 16'h2710);
            ppr_pkg::OFS_DCLIP:   d.cfg.dclip   = lim(pwdata[15:0], 16'h0000, 16'h2710);
            ppr_pkg::OFS_RAMP:    d.cfg.ramp_t  = lim(pwdata[15:0], 16'h0000, 16'hFDE8);
            ppr_pkg::OFS_FBF:     d.cfg.fbf_t   = lim(pwdata[15:0], 16'h0000, 16'h1770);
            ppr_pkg::OFS_OUTF:    d.cfg.outf_t  = lim(pwdata[15:0], 16'h0000, 16'h1770);
            ppr_pkg::OFS_SW_LO:   d.cfg.sw_lo   = lim(pwdata[15:0], 16'h0000, q.cfg.sw_hi);
            ppr_pkg::OFS_SW_HI:   d.cfg.sw_hi   = lim(pwdata[15:0], q.cfg.sw_lo, 16'h2710);
            ppr_pkg::OFS_FMAX:    d.cfg.fmax    = lim(pwdata[15:0], 16'h0001, 16'h7FFF);
            default: begin
               // read-only words ignore writes
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // state register
   // ---------------------------------------------------------------
   // reset loads defaults and clears dynamic states
   // release must be synchronous to pclk upstream
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q     <= '0;
         q.cfg <= ppr_pkg::CFG_RST;
      end else begin
         q <= d;
      end
   end

endmodule : ppr_regulator

// [ppr_regulator_asserts.sv]
`timescale 1ns/1ns
// --------
// regulator port checker
// --------
module ppr_regulator_chk (
   input wire logic               pclk,
   input wire logic               presetn,
   input wire logic [7:0]         paddr,
   input wire logic               psel,
   input wire logic               penable,
   input wire logic               pwrite,
   input wire logic [31:0]        prdata,
   input wire logic               pslverr,
   input wire logic signed [15:0] output_frequency,
   input wire logic signed [31:0] setpoint_display,
   input wire logic signed [31:0] feedback_display
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // read setup phase, where prdata gets loaded
   wire rd_setup = psel && !penable && !pwrite;

   reset_zero_a: assert property ($rose(presetn) |-> output_frequency == 16'sh0000
      && setpoint_display == 32'sh0 && feedback_display == 32'sh0) else $error("outputs not clear");
   freq_tick_a: assert property ($changed(output_frequency) |=>
      $stable(output_frequency)[*8]) else $error("frequency moved between ticks");
   disp_tick_a: assert property ($changed(setpoint_display) |=>
      $stable(setpoint_display)[*8]) else $error("display moved between ticks");
   sp_scale_a: assert property (setpoint_display >= 0 &&
      setpoint_display <= 32'sh0000FFFF) else $error("setpoint display out of range");
   fb_scale_a: assert property (feedback_display >= 0 &&
      feedback_display <= 32'sh0000FFFF) else $error("feedback display out of range");
   freq_read_a: assert property (rd_setup && paddr == 8'h4C |=>
      $signed(prdata) == $past(output_frequency)) else $error("frequency read mismatch");
   bad_read_a: assert property (rd_setup && paddr > 8'h4C |=> prdata == 32'h0)
      else $error("unmapped read not zero");
   bad_addr_a: assert property (psel && penable && paddr > 8'h4C |-> pslverr)
      else $error("unmapped access without error");
endmodule : ppr_regulator_chk

bind ppr_regulator ppr_regulator_chk u_chk (.pclk(pclk), .presetn(presetn), .paddr(paddr),
   .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata), .pslverr(pslverr),
   .output_frequency(output_frequency), .setpoint_display(setpoint_display),
   .feedback_display(feedback_display));

// [ppr_sensor_model.sv]
`timescale 1ns/1ns
// --------
// process sensors and setpoint sources
// --------
module ppr_sensor_model (
   input  wire logic            pclk,
   input  wire logic [15:0]     level,
   output ppr_pkg::ppr_src_type sources
);
   // fixed analog and pulse levels; feedback over communication follows level
   always_ff @(posedge pclk) begin
      sources <= '{16'sh03E8, 16'sh07D0, 16'sh0BB8, 16'sh0FA0, 16'sh1388,
                   $signed(level), 16'sh1770};
   end
endmodule : ppr_sensor_model

// [test_process_pid_regulator.sv]
`timescale 1ns/1ns
// --------
// regulator bench
// --------
module test_process_pid_regulator;
   localparam int SC = 20;  // short tick keeps the run brief
   logic                 pclk = 1'b0;
   logic                 presetn = 1'b0;
   logic [7:0]           paddr = 8'h00;
   logic                 psel = 1'b0;
   logic                 penable = 1'b0;
   logic                 pwrite = 1'b0;
   logic [31:0]          pwdata = 32'h0;
   logic [31:0]          prdata;
   logic                 pready;
   logic                 pslverr;
   logic                 rev_t = 1'b0;
   logic                 gsw_t = 1'b0;
   logic [15:0]          level = 16'h07D0;
   logic signed [15:0]   freq;
   logic signed [15:0]   held;
   logic signed [15:0]   fm[4];
   logic signed [31:0]   sp_disp;
   logic signed [31:0]   fb_disp;
   logic [31:0]          v;
   logic [31:0]          expq[$];
   int                   errors = 0;
   int                   compares = 0;
   ppr_pkg::ppr_src_type src;
   logic [7:0]           ra[8] = '{8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h2C, 8'h3C, 8'h40};
   logic [31:0]          rv[8] = '{32'h1388, 32'h3E8, 32'hC8, 32'hC8, 32'h0, 32'hA,
                                   32'h7D0, 32'h1F40};
   int                   fbx[9] = '{100, 200, 300, 0, 400, 200, 300, 200, 100};

   always #50 pclk = ~pclk;

   ppr_sensor_model u_src (.pclk(pclk), .level(level), .sources(src));
   ppr_regulator #(.SAMPLE_CYCLES(SC)) uut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .sources(src), .reverse_terminal(rev_t),
      .gain_switch_terminal(gsw_t), .output_frequency(freq), .setpoint_display(sp_disp),
      .feedback_display(fb_disp));

   task automatic stop_test;
      $display("errors %0d compares %0d", errors, compares);
      if (errors == 0 && compares > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : stop_test

   // one bus transfer; an idle cycle after it avoids double assignment
   task automatic apb(input logic [7:0] a, input logic [31:0] d, input logic w,
                      input logic [31:0] e);
      psel <= 1'b1;
      paddr <= a;
      pwdata <= d;
      pwrite <= w;
      if (!w) expq.push_back(e);
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb

   task automatic chk(input logic ok);
      compares++;
      if (ok !== 1'b1) begin
         errors++;
         $display("wrong value at %0t: regulator output", $time);
      end
   endtask : chk

   task automatic ticks(input int n);
      repeat (n * SC) @(posedge pclk);
   endtask : ticks

   // read data checked against the oldest note
   always @(posedge pclk) begin
      if (psel && penable && pready && !pwrite) begin
         compares++;
         if (prdata !== expq[0]) begin
            errors++;
            $display("wrong value at %0t: read %h", $time, prdata);
         end
         void'(expq.pop_front());
      end
   end

   initial begin
      repeat (20000) @(posedge pclk);
      errors++;
      stop_test();
   end

   initial begin
      void'($urandom(32'h8275));
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      foreach (ra[i]) apb(ra[i], 32'h0, 1'b0, rv[i]);
      apb(8'h04, 32'hFFFF, 1'b1, 32'h0);
      apb(8'h04, 32'h0, 1'b0, 32'h2710);
      v = 32'hA * $urandom_range(1000);
      apb(8'h04, v, 1'b1, 32'h0);
      apb(8'h04, 32'h0, 1'b0, v);
      apb(8'h50, 32'h0, 1'b0, 32'h0);
      for (int c = 0; c < 7; c++) begin
         apb(8'h00, 32'h50 | c, 1'b1, 32'h0);
         ticks(3);
         chk(sp_disp === (c == 0 ? v / 10 : 32'(c * 100)));
      end
      for (int c = 0; c < 9; c++) begin
         apb(8'h00, 32'(c) << 4, 1'b1, 32'h0);
         ticks(3);
         chk(fb_disp === fbx[c]);
      end
      level <= 16'h0;
      apb(8'h04, 32'h1388, 1'b1, 32'h0);
      apb(8'h00, 32'h50, 1'b1, 32'h0);
      ticks(3);
      chk(freq > 16'sh0);
      apb(8'h24, 32'h64, 1'b1, 32'h0);
      apb(8'h00, 32'h150, 1'b1, 32'h0);
      ticks(3);
      chk(freq === 16'shFF9C);
      apb(8'h4C, 32'h0, 1'b0, 32'hFFFF_FF9C);
      rev_t <= 1'b1;
      ticks(3);
      chk(freq > 16'sh0);
      rev_t <= 1'b0;
      gsw_t <= 1'b1;
      apb(8'h18, 32'h3E8, 1'b1, 32'h0);
      for (int m = 0; m < 4; m++) begin
         apb(8'h00, 32'h50 | (m << 9), 1'b1, 32'h0);
         ticks(8);
         fm[m] = freq;
         chk(freq > 16'sh0);
      end
      chk(fm[0] < fm[3]);
      chk(fm[3] < fm[2]);
      chk(fm[2] < fm[1]);
      apb(8'h28, 32'h2710, 1'b1, 32'h0);
      ticks(1);
      held = freq;
      level <= 16'h0BB8;
      ticks(3);
      chk(freq === held);
      apb(8'h30, 32'h64, 1'b1, 32'h0);
      apb(8'h34, 32'h64, 1'b1, 32'h0);
      apb(8'h04, 32'h2710, 1'b1, 32'h0);
      level <= 16'h0;
      ticks(3);
      chk(sp_disp >= 501 && sp_disp <= 504);
      chk(fb_disp >= 295 && fb_disp <= 299);
      stop_test();
   end
endmodule : test_process_pid_regulator
